// ### hw/fps_pkg.sv
package fps_pkg;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_PAGE_PROGRAM       = 8'h02;
  localparam logic [7:0] OP_PAGE_PROGRAM_4B    = 8'h12;
  localparam logic [7:0] OP_QUAD_PROGRAM_A     = 8'h32;
  localparam logic [7:0] OP_QUAD_PROGRAM_B     = 8'h38;
  localparam logic [7:0] OP_QUAD_PROGRAM_4B_A  = 8'h34;
  localparam logic [7:0] OP_QUAD_PROGRAM_4B_B  = 8'h3E;
  localparam logic [7:0] OP_SECTOR_ERASE_A     = 8'hD7;
  localparam logic [7:0] OP_SECTOR_ERASE_B     = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_4B    = 8'h21;
  localparam logic [7:0] OP_BLOCK32_ERASE      = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE      = 8'hD8;
  localparam logic [7:0] OP_BLOCK32_ERASE_4B   = 8'h5C;
  localparam logic [7:0] OP_BLOCK64_ERASE_4B   = 8'hDC;
  localparam logic [7:0] OP_WHOLE_ERASE_A      = 8'hC7;
  localparam logic [7:0] OP_WHOLE_ERASE_B      = 8'h60;

  // ************************************************************
  // Geometry, counts and reset values
  // ************************************************************
  localparam int unsigned PAGE_AW        = 8;
  localparam int unsigned SECTOR_AW      = 12;
  localparam int unsigned BLK32_SECTORS  = 8;
  localparam int unsigned BLK64_SECTORS  = 16;
  localparam logic [2:0]  ADDR_BYTES_STD = 3'h3;
  localparam logic [2:0]  ADDR_BYTES_EXT = 3'h4;
  localparam logic [2:0]  ADDR_BYTES_NONE = 3'h0;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic        WEL_RESET      = 1'b0;
  localparam int unsigned BP_W           = 4;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_WRITE_ENABLE,
    CMD_PROGRAM,
    CMD_SECTOR,
    CMD_BLOCK32,
    CMD_BLOCK64,
    CMD_WHOLE
  } fps_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROGRAM,
    ST_ERASE
  } fps_state_t;

endpackage : fps_pkg

// ### hw/fps_sync.sv
`timescale 1ns/10ps
module fps_sync #(
  parameter int unsigned       WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import fps_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ************************************************************
  // Two-stage synchroniser
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : fps_sync

// ### hw/fps_rx.sv
`timescale 1ns/10ps
module fps_rx (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       cs_n_in,
  input  wire logic       sclk_in,
  input  wire logic [3:0] data_in,
  input  wire logic       quad_in,
  output logic            frame_start_out,
  output logic            frame_end_out,
  output logic            end_aligned_out,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out
);
  import fps_pkg::*;

  logic       sclk_q;
  logic       cs_n_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic       start_q;
  logic       end_q;
  logic       aligned_q;
  logic       valid_q;
  logic [7:0] byte_q;
  logic       rise;
  logic [7:0] shift_d;
  logic [3:0] bit_cnt_d;

  // ************************************************************
  // Edge detection on the sampled link clock
  // ************************************************************
  assign rise      = sclk_in & ~sclk_q & ~cs_n_in;
  assign shift_d   = quad_in ? {shift_q[3:0], data_in}
                             : {shift_q[6:0], data_in[0]};
  assign bit_cnt_d = bit_cnt_q + (quad_in ? 4'h4 : 4'h1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_in;
      cs_n_q <= cs_n_in;
    end
  end

  // ************************************************************
  // Frame edges
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_q   <= 1'b0;
      end_q     <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      start_q   <= cs_n_q & ~cs_n_in;
      end_q     <= ~cs_n_q & cs_n_in;
      aligned_q <= (bit_cnt_q == 4'h0);
    end
  end

  // ************************************************************
  // Bit assembly, MSB first
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      valid_q   <= 1'b0;
      byte_q    <= 8'h00;
    end else begin
      valid_q <= 1'b0;
      if (cs_n_q & ~cs_n_in) begin
        bit_cnt_q <= 4'h0;
      end else if (rise) begin
        shift_q <= shift_d;
        if (bit_cnt_d == BITS_PER_BYTE) begin
          bit_cnt_q <= 4'h0;
          valid_q   <= 1'b1;
          byte_q    <= shift_d;
        end else begin
          bit_cnt_q <= bit_cnt_d;
        end
      end
    end
  end

  assign frame_start_out = start_q;
  assign frame_end_out   = end_q;
  assign end_aligned_out = aligned_q;
  assign byte_valid_out  = valid_q;
  assign byte_out        = byte_q;

endmodule : fps_rx

// ### hw/fps_flash_seq.sv
`timescale 1ns/10ps
module fps_flash_seq #(
  parameter int unsigned MEM_AW = 16
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           reset_n_in,
  input  wire logic                           chip_select_n_in,
  input  wire logic                           serial_clock_in,
  input  wire logic [3:0]                     data_line_in,
  input  wire logic                           extended_address_sel_in,
  input  wire logic                           quad_enable_in,
  input  wire logic                           four_line_command_mode_in,
  input  wire logic [fps_pkg::BP_W-1:0]       block_protect_bits_in,
  input  wire logic [(1<<(MEM_AW-12))-1:0]    dynamic_protect_bits_in,
  input  wire logic [(1<<(MEM_AW-12))-1:0]    persistent_protect_bits_in,
  input  wire logic                           clear_error_flags_in,
  input  wire logic [MEM_AW-1:0]              read_addr_in,
  output logic      [7:0]                     read_data_out,
  output logic                                write_enable_latch_out,
  output logic                                write_in_progress_out,
  output logic                                erase_error_flag_out,
  output logic                                protection_error_flag_out
);
  import fps_pkg::*;

  localparam int unsigned NSEC  = 1 << (MEM_AW - SECTOR_AW);
  localparam int unsigned SEC_W = MEM_AW - SECTOR_AW;
  localparam int unsigned NPAGE = 1 << PAGE_AW;

  // ************************************************************
  // Elaboration check
  // ************************************************************
  generate
    if (MEM_AW < 16 || MEM_AW > 24) begin : g_bad_aw
      $error("MEM_AW must lie between 16 and 24");
    end
  endgenerate

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic bp_prot(input logic [SEC_W-1:0] s,
                                   input logic [BP_W-1:0]  bp);
    int top;
    top = int'(NSEC) - 1 - int'(s);
    bp_prot = (bp != '0) && (top < (1 << (int'(bp) - 1)));
  endfunction : bp_prot

  function automatic logic asp_prot(input logic [SEC_W-1:0] s);
    asp_prot = dynamic_protect_bits_in[s] | persistent_protect_bits_in[s];
  endfunction : asp_prot

  function automatic logic region_prot(input logic [SEC_W-1:0] lo,
                                       input int unsigned      n);
    region_prot = 1'b0;
    for (int i = 0; i < NSEC; i++) begin
      if (i >= int'(lo) && i < int'(lo) + int'(n) &&
          (asp_prot(SEC_W'(i)) || bp_prot(SEC_W'(i),
                                           block_protect_bits_in))) begin
        region_prot = 1'b1;
      end
    end
  endfunction : region_prot

  // ************************************************************
  // Pin synchronisers and frame receiver
  // ************************************************************
  logic [5:0] pins_s;
  logic       frame_start;
  logic       frame_end;
  logic       end_aligned;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       lane_quad;

  fps_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h20)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({chip_select_n_in, serial_clock_in, data_line_in}),
    .sync_out   (pins_s)
  );

  fps_rx u_rx (
    .sys_clk_in      (sys_clk_in),
    .reset_n_in      (reset_n_in),
    .cs_n_in         (pins_s[5]),
    .sclk_in         (pins_s[4]),
    .data_in         (pins_s[3:0]),
    .quad_in         (lane_quad),
    .frame_start_out (frame_start),
    .frame_end_out   (frame_end),
    .end_aligned_out (end_aligned),
    .byte_valid_out  (byte_valid),
    .byte_out        (rx_byte)
  );

  // ************************************************************
  // Frame capture
  // ************************************************************
  fps_state_t           state_q;
  fps_cmd_t             cmd_q;
  logic                 cmd_quad_q;
  logic                 frame_qpi_q;
  logic [2:0]           addr_len_q;
  logic [2:0]           hdr_cnt_q;
  logic [31:0]          addr_q;
  logic [PAGE_AW-1:0]   page_ptr_q;
  logic [NPAGE-1:0]     mask_q;
  logic                 got_data_q;
  logic                 extra_q;
  logic [7:0]           page_buf [NPAGE];
  logic                 capture;

  assign capture   = (state_q == ST_IDLE);
  assign lane_quad = frame_qpi_q | (cmd_quad_q & (hdr_cnt_q != 3'h0));

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q       <= CMD_NONE;
      cmd_quad_q  <= 1'b0;
      frame_qpi_q <= 1'b0;
      addr_len_q  <= ADDR_BYTES_NONE;
      hdr_cnt_q   <= 3'h0;
      addr_q      <= 32'h0;
      page_ptr_q  <= '0;
      got_data_q  <= 1'b0;
      extra_q     <= 1'b0;
    end else if (frame_start) begin
      frame_qpi_q <= four_line_command_mode_in;
      cmd_q       <= CMD_NONE;
      cmd_quad_q  <= 1'b0;
      hdr_cnt_q   <= 3'h0;
      got_data_q  <= 1'b0;
      extra_q     <= 1'b0;
    end else if (byte_valid && capture) begin
      if (hdr_cnt_q == 3'h0) begin
        hdr_cnt_q  <= 3'h1;
        cmd_quad_q <= 1'b0;
        addr_len_q <= extended_address_sel_in ? ADDR_BYTES_EXT
                                              : ADDR_BYTES_STD;
        unique case (rx_byte)
          OP_WRITE_ENABLE_CMD: begin
            cmd_q      <= CMD_WRITE_ENABLE;
            addr_len_q <= ADDR_BYTES_NONE;
          end
          OP_PAGE_PROGRAM: cmd_q <= CMD_PROGRAM;
          OP_PAGE_PROGRAM_4B: begin
            cmd_q      <= CMD_PROGRAM;
            addr_len_q <= ADDR_BYTES_EXT;
          end
          OP_QUAD_PROGRAM_A, OP_QUAD_PROGRAM_B: begin
            cmd_q      <= CMD_PROGRAM;
            cmd_quad_q <= 1'b1;
          end
          OP_QUAD_PROGRAM_4B_A, OP_QUAD_PROGRAM_4B_B: begin
            cmd_q      <= CMD_PROGRAM;
            cmd_quad_q <= 1'b1;
            addr_len_q <= ADDR_BYTES_EXT;
          end
          OP_SECTOR_ERASE_A, OP_SECTOR_ERASE_B: cmd_q <= CMD_SECTOR;
          OP_SECTOR_ERASE_4B: begin
            cmd_q      <= CMD_SECTOR;
            addr_len_q <= ADDR_BYTES_EXT;
          end
          OP_BLOCK32_ERASE: cmd_q <= CMD_BLOCK32;
          OP_BLOCK64_ERASE: cmd_q <= CMD_BLOCK64;
          OP_BLOCK32_ERASE_4B: begin
            cmd_q      <= CMD_BLOCK32;
            addr_len_q <= ADDR_BYTES_EXT;
          end
          OP_BLOCK64_ERASE_4B: begin
            cmd_q      <= CMD_BLOCK64;
            addr_len_q <= ADDR_BYTES_EXT;
          end
          OP_WHOLE_ERASE_A, OP_WHOLE_ERASE_B: begin
            cmd_q      <= CMD_WHOLE;
            addr_len_q <= ADDR_BYTES_NONE;
          end
          default: cmd_q <= CMD_NONE;
        endcase
      end else if (hdr_cnt_q <= addr_len_q) begin
        hdr_cnt_q  <= hdr_cnt_q + 3'h1;
        addr_q     <= {addr_q[23:0], rx_byte};
        page_ptr_q <= rx_byte;
      end else if (cmd_q == CMD_PROGRAM) begin
        page_ptr_q <= page_ptr_q + 1'b1;
        got_data_q <= 1'b1;
      end else begin
        extra_q <= 1'b1;
      end
    end
  end

  // Buffer has no reset; the mask alone says which bytes are live
  always_ff @(posedge sys_clk_in) begin
    if (byte_valid && capture && cmd_q == CMD_PROGRAM &&
        hdr_cnt_q > addr_len_q) begin
      page_buf[page_ptr_q] <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= '0;
    end else if (frame_start) begin
      mask_q <= '0;
    end else if (byte_valid && capture && cmd_q == CMD_PROGRAM &&
                 hdr_cnt_q > addr_len_q) begin
      mask_q[page_ptr_q] <= 1'b1;
    end
  end

  // ************************************************************
  // Command acceptance at chip-select rise
  // ************************************************************
  logic              hdr_done;
  logic              frame_ok;
  logic [SEC_W-1:0]  sec;
  logic [SEC_W-1:0]  lo_sec;
  int unsigned       n_sec;
  logic              go_prog;
  logic              go_erase;
  logic              whole_refused;
  logic              wel_q;

  assign hdr_done = (hdr_cnt_q == addr_len_q + 3'h1) && !extra_q;
  assign frame_ok = frame_end && end_aligned && capture && hdr_done;
  assign sec      = addr_q[MEM_AW-1:SECTOR_AW];

  always_comb begin
    lo_sec = sec;
    n_sec  = 1;
    unique case (cmd_q)
      CMD_BLOCK32: begin
        lo_sec = sec & ~SEC_W'(BLK32_SECTORS - 1);
        n_sec  = BLK32_SECTORS;
      end
      CMD_BLOCK64: begin
        lo_sec = sec & ~SEC_W'(BLK64_SECTORS - 1);
        n_sec  = BLK64_SECTORS;
      end
      CMD_WHOLE: begin
        lo_sec = '0;
        n_sec  = NSEC;
      end
      default: begin
        lo_sec = sec;
        n_sec  = 1;
      end
    endcase
  end

  // Refusals leave the latch, array and busy flag alone
  assign go_prog = frame_ok && cmd_q == CMD_PROGRAM && got_data_q &&
                   wel_q && (!cmd_quad_q || quad_enable_in) &&
                   !region_prot(sec, 1);
  assign go_erase = frame_ok && wel_q &&
                    (((cmd_q == CMD_SECTOR || cmd_q == CMD_BLOCK32 ||
                       cmd_q == CMD_BLOCK64) &&
                      !region_prot(lo_sec, n_sec)) ||
                     (cmd_q == CMD_WHOLE &&
                      block_protect_bits_in == '0));
  assign whole_refused = frame_ok && wel_q && cmd_q == CMD_WHOLE &&
                         block_protect_bits_in != '0;

  // ************************************************************
  // Self-timed walk over the array
  // ************************************************************
  logic [MEM_AW-1:0] ptr_q;
  logic [MEM_AW-1:0] last_q;
  logic              skip_asp_q;
  logic              wip_q;
  logic              walk_done;
  logic              wr_en;
  logic [7:0]        wr_data;
  logic [7:0]        mem [1 << MEM_AW];

  assign walk_done = (state_q != ST_IDLE) && (ptr_q == last_q);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q    <= ST_IDLE;
      ptr_q      <= '0;
      last_q     <= '0;
      skip_asp_q <= 1'b0;
      wip_q      <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go_prog) begin
            state_q <= ST_PROGRAM;
            wip_q   <= 1'b1;
            ptr_q   <= {addr_q[MEM_AW-1:PAGE_AW], PAGE_AW'(0)};
            last_q  <= {addr_q[MEM_AW-1:PAGE_AW], {PAGE_AW{1'b1}}};
          end else if (go_erase) begin
            state_q    <= ST_ERASE;
            wip_q      <= 1'b1;
            skip_asp_q <= (cmd_q == CMD_WHOLE);
            ptr_q      <= {lo_sec, SECTOR_AW'(0)};
            last_q     <= {lo_sec + SEC_W'(n_sec - 1),
                           {SECTOR_AW{1'b1}}};
          end
        end
        ST_PROGRAM, ST_ERASE: begin
          if (walk_done) begin
            state_q <= ST_IDLE;
            wip_q   <= 1'b0;
          end else begin
            ptr_q <= ptr_q + 1'b1;
          end
        end
      endcase
    end
  end

  always_comb begin
    wr_en   = 1'b0;
    wr_data = ERASED_BYTE;
    if (state_q == ST_PROGRAM) begin
      wr_en   = mask_q[ptr_q[PAGE_AW-1:0]];
      wr_data = mem[ptr_q] & page_buf[ptr_q[PAGE_AW-1:0]];
    end else if (state_q == ST_ERASE) begin
      wr_en   = !(skip_asp_q && asp_prot(ptr_q[MEM_AW-1:SECTOR_AW]));
      wr_data = ERASED_BYTE;
    end
  end

  // Contents are undefined until the first erase of each region
  always_ff @(posedge sys_clk_in) begin
    if (wr_en) begin
      mem[ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_data_out <= 8'h00;
    end else begin
      read_data_out <= mem[read_addr_in];
    end
  end

  // ************************************************************
  // Write enable latch and error flags
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wel_q <= WEL_RESET;
    end else if (walk_done) begin
      wel_q <= 1'b0;
    end else if (frame_ok && cmd_q == CMD_WRITE_ENABLE) begin
      wel_q <= 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      erase_error_flag_out      <= 1'b0;
      protection_error_flag_out <= 1'b0;
    end else if (whole_refused) begin
      erase_error_flag_out      <= 1'b1;
      protection_error_flag_out <= 1'b1;
    end else if (clear_error_flags_in) begin
      erase_error_flag_out      <= 1'b0;
      protection_error_flag_out <= 1'b0;
    end
  end

  assign write_enable_latch_out = wel_q;
  assign write_in_progress_out  = wip_q;

endmodule : fps_flash_seq

// ### test/fps_flash_seq_properties.sv
`timescale 1ns/10ps
// ****
// Checker
// ****
module fps_flash_seq_properties (
  input wire logic                      sys_clk_in,
  input wire logic                      reset_n_in,
  input wire logic                      chip_select_n_in,
  input wire logic [fps_pkg::BP_W-1:0]  block_protect_bits_in,
  input wire logic                      clear_error_flags_in,
  input wire logic                      write_enable_latch_out,
  input wire logic                      write_in_progress_out,
  input wire logic                      erase_error_flag_out,
  input wire logic                      protection_error_flag_out
);
  import fps_pkg::*;
  logic [16:0] busy_q;
  // Busy length counter; 17 bits hold a whole-array erase
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) busy_q <= 17'h00000;
    else busy_q <= write_in_progress_out ? busy_q + 17'h00001 : 17'h00000;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_done; !write_enable_latch_out ##1 !write_in_progress_out;
  endsequence
  property p_busy_wel; write_in_progress_out |-> write_enable_latch_out;
  endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("busy, no latch");
  property p_busy_start; $rose(write_in_progress_out) |->
    chip_select_n_in && $past(chip_select_n_in, 3); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy early");
  property p_busy_len; $fell(write_in_progress_out) |->
    busy_q inside {[17'h000FF:17'h00101]} || busy_q >= 17'h00FFF; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_busy_end; $fell(write_in_progress_out) |-> s_done; endproperty
  a_busy_end: assert property (p_busy_end) else $error("latch kept");
  property p_wel_idle; $rose(write_enable_latch_out) |->
    !write_in_progress_out; endproperty
  a_wel_idle: assert property (p_wel_idle) else $error("latch while busy");
  property p_err_pair; erase_error_flag_out == protection_error_flag_out;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("flags differ");
  property p_err_cause; $rose(erase_error_flag_out) |-> write_enable_latch_out
    && !write_in_progress_out && block_protect_bits_in != '0; endproperty
  a_err_cause: assert property (p_err_cause) else $error("bad error");
  property p_err_hold; erase_error_flag_out && !clear_error_flags_in |=>
    erase_error_flag_out; endproperty
  a_err_hold: assert property (p_err_hold) else $error("flag lost");
endmodule : fps_flash_seq_properties

bind fps_flash_seq fps_flash_seq_properties i_fps_flash_seq_properties (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .chip_select_n_in(chip_select_n_in),
  .block_protect_bits_in(block_protect_bits_in),
  .clear_error_flags_in(clear_error_flags_in),
  .write_enable_latch_out(write_enable_latch_out),
  .write_in_progress_out(write_in_progress_out),
  .erase_error_flag_out(erase_error_flag_out),
  .protection_error_flag_out(protection_error_flag_out));

// ### test/fps_host_model.sv
`timescale 1ns/10ps
// ****
// Host link model
// ****
module fps_host_model (
  output logic       cs_n_out,
  output logic       sclk_out,
  output logic [3:0] data_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    data_out = 4'h0;
  end
  // Mode 0, clock still outside frames, odd offset keeps it off sys edges
  task automatic frame(input logic quad, input logic [7:0] q[$]);
    logic [7:0] b;
    cs_n_out = 1'b0;
    #213;
    foreach (q[i]) begin
      b = q[i];
      for (int k = 0; k < (quad ? 2 : 8); k++) begin
        data_out = quad ? b[7:4] : {b[6:4], b[7]};
        b = quad ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
        #160 sclk_out = 1'b1;
        #160 sclk_out = 1'b0;
      end
    end
    #100 cs_n_out = 1'b1;
    data_out = ~data_out;
    #800;
  endtask : frame
endmodule : fps_host_model

// ### test/testbench.sv
`timescale 1ns/10ps
// ****
// Bench
// ****
module testbench;
  import fps_pkg::*;
  logic        sys_clk_in = 1'b0, reset_n_in = 1'b0, cs_n, sclk;
  logic        ext = 1'b0, qe = 1'b0, four_line_command_mode = 1'b0, clr = 1'b0;
  logic        write_enable_latch, write_in_progress, eerr, perr;
  logic [3:0]  dl, bp = 4'h0;
  logic [15:0] dyn = 16'h0000, ra = 16'h0000;
  logic [7:0]  rdata;
  logic [7:0]  dq[$];
  int          n_fail, tests_run, cyc;
  always #20 sys_clk_in = ~sys_clk_in;
  fps_host_model i_fps_host_model (.cs_n_out(cs_n), .sclk_out(sclk),
    .data_out(dl));
  fps_flash_seq #(.MEM_AW(16)) i_fps_flash_seq (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .chip_select_n_in(cs_n), .serial_clock_in(sclk), .data_line_in(dl),
    .extended_address_sel_in(ext), .quad_enable_in(qe),
    .four_line_command_mode_in(four_line_command_mode), .block_protect_bits_in(bp),
    .dynamic_protect_bits_in(dyn), .persistent_protect_bits_in(16'h0000),
    .clear_error_flags_in(clr), .read_addr_in(ra), .read_data_out(rdata),
    .write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress),
    .erase_error_flag_out(eerr), .protection_error_flag_out(perr));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk_bit(string n, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_byte
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  // Sends one frame, checks busy, then waits out the operation
  task automatic tx(logic [7:0] op, logic [31:0] a, int na, logic busy);
    logic [7:0] q[$];
    q = {op};
    for (int i = na - 1; i >= 0; i--) q.push_back(a[8*i+:8]);
    q = {q, dq};
    dq = {};
    i_fps_host_model.frame(four_line_command_mode, q);
    chk_bit("busy", busy, write_in_progress);
    for (int i = 0; i < 70000 && write_in_progress; i++) tick(1);
    tick(1);
  endtask : tx
  task automatic write_enable_cmd();
    tx(OP_WRITE_ENABLE_CMD, 32'h0, 0, 1'b0);
    chk_bit("wel", 1'b1, write_enable_latch);
  endtask : write_enable_cmd
  task automatic rd(logic [15:0] a, logic [7:0] e);
    ra = a;
    tick(2);
    chk_byte("mem", e, rdata);
  endtask : rd
  initial begin
    tick(6);
    reset_n_in = 1'b1;
    tick(4);
    write_enable_cmd();
    tx(OP_SECTOR_ERASE_B, 32'h0, 3, 1'b1);
    chk_bit("wel", 1'b0, write_enable_latch);
    rd(16'h0FFF, ERASED_BYTE);
    $display("erase done");
    dq = {8'hA5};
    tx(OP_PAGE_PROGRAM, 32'h10, 3, 1'b0);
    rd(16'h0010, ERASED_BYTE);
    write_enable_cmd();
    dq = {8'hA5, 8'h3C};
    tx(OP_PAGE_PROGRAM, 32'h10, 3, 1'b1);
    rd(16'h0012, ERASED_BYTE);
    write_enable_cmd();
    dq = {8'hF0};
    tx(OP_PAGE_PROGRAM_4B, 32'h10, 4, 1'b1);
    rd(16'h0010, 8'hA0);
    ext = 1'b1;
    write_enable_cmd();
    dq = {8'h0F};
    tx(OP_PAGE_PROGRAM, 32'h11, 4, 1'b1);
    rd(16'h0011, 8'h0C);
    ext = 1'b0;
    $display("program done");
    four_line_command_mode = 1'b1;
    write_enable_cmd();
    dq = {8'h00};
    tx(OP_QUAD_PROGRAM_A, 32'h20, 3, 1'b0);
    chk_bit("wel", 1'b1, write_enable_latch);
    qe = 1'b1;
    for (int k = 0; k < 256; k++) dq.push_back(k[7:0]);
    dq = {dq, 8'h5A, 8'h69};
    tx(OP_QUAD_PROGRAM_B, 32'h20, 3, 1'b1);
    rd(16'h0020, 8'h5A);
    rd(16'h0022, 8'h02);
    rd(16'h0001, 8'hE1);
    four_line_command_mode = 1'b0;
    $display("quad done");
    dyn = 16'h0001;
    write_enable_cmd();
    dq = {8'h00};
    tx(OP_PAGE_PROGRAM, 32'h130, 3, 1'b0);
    tx(OP_BLOCK32_ERASE, 32'h0, 3, 1'b0);
    rd(16'h0130, ERASED_BYTE);
    bp = 4'h1;
    tx(OP_WHOLE_ERASE_A, 32'h0, 0, 1'b0);
    chk_bit("perr", 1'b1, perr);
    chk_bit("wel", 1'b1, write_enable_latch);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tx(OP_WHOLE_ERASE_B, 32'h0, 0, 1'b0);
    chk_bit("eerr", 1'b1, eerr);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    bp = 4'h0;
    dyn = 16'h0000;
    tick(2);
    chk_bit("eerr", 1'b0, eerr);
    tx(OP_SECTOR_ERASE_4B, 32'h0, 4, 1'b1);
    rd(16'h0011, ERASED_BYTE);
    $display("protect done");
    write_enable_cmd();
    dq = {8'h5A};
    tx(OP_PAGE_PROGRAM, 32'h11, 3, 1'b1);
    write_enable_cmd();
    dyn = 16'h0001;
    tx(OP_WHOLE_ERASE_A, 32'h0, 0, 1'b1);
    chk_bit("wel", 1'b0, write_enable_latch);
    chk_bit("eerr", 1'b0, eerr);
    chk_bit("perr", 1'b0, perr);
    rd(16'h0011, 8'h5A);
    rd(16'hFFFF, ERASED_BYTE);
    dyn = 16'h0000;
    $display("whole erase done");
    report_and_stop();
  end
endmodule : testbench
